// ===== core/haptic_player_regs.svh
// Register offsets, field positions and timing counts of the sample player
`ifndef HAPTIC_PLAYER_REGS_SVH
`define HAPTIC_PLAYER_REGS_SVH
`define PTR_OFFSET 8'h40
`define HIGH_OFFSET 8'h41
`define MIDDLE_OFFSET 8'h42
`define LOW_OFFSET 8'h43
`define SEQ_MSB 23
`define SEQ_LSB 22
`define POL_BIT 21
`define AMP_HI_MSB 20
`define AMP_HI_LSB 16
`define AMP_LO_MSB 15
`define AMP_LO_LSB 14
`define HOLD_MSB 13
`define HOLD_LSB 9
`define GAP_HI_BIT 8
`define GAP_LO_MSB 7
`define GAP_LO_LSB 4
`define RPT_MSB 3
`define RPT_LSB 0
`define STEP_MS 5
`define CLK_KHZ 40000
`define STEP_CYCLES (`STEP_MS * `CLK_KHZ)
`define PTR_RESET 8'h00
`endif

// ===== core/haptic_player_pkg.sv
// Types shared by the sample player files
package haptic_player_pkg;
  typedef logic [23:0] sample_word_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    SEQ_LAST, SEQ_CONTINUE, SEQ_INTERP, SEQ_REPEAT_ALL
  } seq_code_t;
  typedef enum {
    ST_IDLE, ST_FETCH, ST_HOLD, ST_GAP, ST_BRAKE
  } play_state_t;
endpackage

// ===== core/step_timer.sv
// Counts whole 5 ms steps and pulses when the programmed count is reached
`timescale 1ns/1ps
`include "haptic_player_regs.svh"
module step_timer #(
  parameter int STEP_CYCLES = `STEP_CYCLES
) (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Async reset
  input wire logic start_i, // Load and start
  input wire logic [4:0] steps_i, // Step count
  output logic done_o // One-cycle end pulse
);
  if (STEP_CYCLES < 1) begin
    $error("STEP_CYCLES must be positive");
  end
  logic [31:0] cyc, next_cyc;
  logic [4:0] left, next_left;
  logic run, next_run, next_done;
  always_comb begin
    next_cyc = cyc;
    next_left = left;
    next_run = run;
    next_done = 1'b0;
    if (start_i) begin
      next_cyc = 32'h0;
      next_left = steps_i;
      next_run = (steps_i != 5'h0);
      next_done = (steps_i == 5'h0);
    end else if (run) begin
      if (cyc == 32'(STEP_CYCLES - 1)) begin
        next_cyc = 32'h0;
        next_left = left - 5'h1;
        if (left == 5'h1) begin
          next_run = 1'b0;
          next_done = 1'b1;
        end
      end else begin
        next_cyc = cyc + 32'h1;
      end
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc <= 32'h0;
      left <= 5'h0;
      run <= 1'b0;
      done_o <= 1'b0;
    end else begin
      cyc <= next_cyc;
      left <= next_left;
      run <= next_run;
      done_o <= next_done;
    end
  end
endmodule

// ===== core/haptic_pattern_sample_player.sv
// Pattern RAM, register access and playback of stored haptic samples
`timescale 1ns/1ps
`include "haptic_player_regs.svh"
module haptic_pattern_sample_player #(
  parameter int DEPTH = 256,
  parameter int STEP_CYCLES = `STEP_CYCLES
) (
  input wire logic clk_i, // Clock, 40 MHz
  input wire logic reset_i, // Async reset, active high
  input wire logic [7:0] reg_addr_i, // Register offset
  input wire haptic_player_pkg::byte_t reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic play_i, // Start pulse
  input wire logic stop_i, // Abort pulse
  output haptic_player_pkg::byte_t reg_rdata_o, // Read data
  output logic [6:0] level_o, // Drive amplitude
  output logic level_polarity_o, // 1 negative
  output logic brake_o, // Braking active
  output logic busy_o // Playback running
);
  import haptic_player_pkg::*;
  if (DEPTH < 2 || DEPTH > 256) begin
    $error("DEPTH must be 2..256");
  end

  sample_word_t ram [DEPTH];
  byte_t pattern_ram_pointer, next_pointer;
  byte_t pattern_sample_high_byte, pattern_sample_middle_byte;
  byte_t pattern_sample_low_byte;
  byte_t next_high, next_middle, next_low, next_rdata;
  logic ram_we;
  sample_word_t ram_wdata;

  function automatic logic [6:0] amp_of(input sample_word_t w);
    return {w[`AMP_HI_MSB:`AMP_HI_LSB], w[`AMP_LO_MSB:`AMP_LO_LSB]};
  endfunction
  function automatic logic [4:0] gap_of(input sample_word_t w);
    return {w[`GAP_HI_BIT], w[`GAP_LO_MSB:`GAP_LO_LSB]};
  endfunction

  // Staging bytes; low byte write commits the word at the pointer
  always_comb begin
    next_pointer = pattern_ram_pointer;
    next_high = pattern_sample_high_byte;
    next_middle = pattern_sample_middle_byte;
    next_low = pattern_sample_low_byte;
    next_rdata = reg_rdata_o;
    ram_we = 1'b0;
    ram_wdata = {pattern_sample_high_byte, pattern_sample_middle_byte,
                 reg_wdata_i};
    if (reg_wr_i) begin
      case (reg_addr_i)
        `PTR_OFFSET: begin
          next_pointer = reg_wdata_i;
          next_high = ram[reg_wdata_i][23:16];
          next_middle = ram[reg_wdata_i][15:8];
          next_low = ram[reg_wdata_i][7:0];
        end
        `HIGH_OFFSET: next_high = reg_wdata_i;
        `MIDDLE_OFFSET: next_middle = reg_wdata_i;
        `LOW_OFFSET: begin
          next_low = reg_wdata_i;
          ram_we = 1'b1;
          next_pointer = pattern_ram_pointer + 8'h01;
        end
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `PTR_OFFSET: next_rdata = pattern_ram_pointer;
        `HIGH_OFFSET: next_rdata = pattern_sample_high_byte;
        `MIDDLE_OFFSET: next_rdata = pattern_sample_middle_byte;
        `LOW_OFFSET: next_rdata = pattern_sample_low_byte;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (ram_we && 32'(pattern_ram_pointer) < DEPTH) begin
      ram[pattern_ram_pointer] <= ram_wdata;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pattern_ram_pointer <= `PTR_RESET;
      pattern_sample_high_byte <= 8'h00;
      pattern_sample_middle_byte <= 8'h00;
      pattern_sample_low_byte <= 8'h00;
      reg_rdata_o <= 8'h00;
    end else begin
      pattern_ram_pointer <= next_pointer;
      pattern_sample_high_byte <= next_high;
      pattern_sample_middle_byte <= next_middle;
      pattern_sample_low_byte <= next_low;
      reg_rdata_o <= next_rdata;
    end
  end

  // Playback engine
  play_state_t state, next_state;
  byte_t play_addr, next_play_addr, start_addr, next_start_addr;
  sample_word_t cur, next_cur;
  logic [3:0] rpt_left, next_rpt_left, pat_left, next_pat_left;
  logic pat_armed, next_pat_armed;
  logic [6:0] next_level;
  logic next_polarity, next_brake, next_busy;
  logic tmr_start, tmr_done;
  logic [4:0] tmr_steps;
  seq_code_t seq;
  sample_word_t nxt_word;

  assign seq = seq_code_t'(cur[`SEQ_MSB:`SEQ_LSB]);
  assign nxt_word = ram[play_addr + 8'h01];

  step_timer #(.STEP_CYCLES(STEP_CYCLES)) timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(tmr_start),
    .steps_i(tmr_steps),
    .done_o(tmr_done)
  );

  always_comb begin
    next_state = state;
    next_play_addr = play_addr;
    next_start_addr = start_addr;
    next_cur = cur;
    next_rpt_left = rpt_left;
    next_pat_left = pat_left;
    next_pat_armed = pat_armed;
    next_level = level_o;
    next_polarity = level_polarity_o;
    next_brake = 1'b0;
    next_busy = (state != ST_IDLE);
    tmr_start = 1'b0;
    tmr_steps = 5'h0;
    case (state)
      ST_IDLE: begin
        next_level = 7'h00;
        if (play_i) begin
          next_play_addr = pattern_ram_pointer;
          next_start_addr = pattern_ram_pointer;
          next_pat_armed = 1'b0;
          next_state = ST_FETCH;
          next_busy = 1'b1;
        end
      end
      ST_FETCH: begin
        next_cur = ram[play_addr];
        next_rpt_left = ram[play_addr][`RPT_MSB:`RPT_LSB];
        next_level = amp_of(ram[play_addr]);
        next_polarity = ram[play_addr][`POL_BIT];
        tmr_steps = ram[play_addr][`HOLD_MSB:`HOLD_LSB];
        tmr_start = 1'b1;
        next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (tmr_done) begin
          next_level = 7'h00;
          // Interpolated sample ends on the next sample's level
          if (seq == SEQ_INTERP) begin
            next_level = amp_of(nxt_word);
          end
          tmr_steps = gap_of(cur);
          tmr_start = 1'b1;
          if (seq == SEQ_LAST && cur[`RPT_MSB:`RPT_LSB] == 4'h0) begin
            next_state = ST_BRAKE;
            next_brake = 1'b1;
          end else begin
            next_state = ST_GAP;
          end
        end
      end
      ST_GAP, ST_BRAKE: begin
        next_level = 7'h00;
        next_brake = (state == ST_BRAKE);
        if (tmr_done) begin
          // Brake flag drops with the state, never outlives playback
          next_brake = 1'b0;
          next_state = ST_FETCH;
          if (seq != SEQ_REPEAT_ALL && rpt_left != 4'h0) begin
            next_rpt_left = rpt_left - 4'h1;
            next_cur = cur;
            next_state = ST_HOLD;
            next_level = amp_of(cur);
            tmr_steps = cur[`HOLD_MSB:`HOLD_LSB];
            tmr_start = 1'b1;
          end else if (seq == SEQ_CONTINUE || seq == SEQ_INTERP) begin
            next_play_addr = play_addr + 8'h01;
          end else if (seq == SEQ_REPEAT_ALL) begin
            if (!pat_armed) begin
              next_pat_armed = 1'b1;
              next_pat_left = cur[`RPT_MSB:`RPT_LSB];
            end
            if ((!pat_armed && cur[`RPT_MSB:`RPT_LSB] != 4'h0) ||
                (pat_armed && pat_left != 4'h0)) begin
              next_pat_left = (pat_armed ? pat_left :
                               cur[`RPT_MSB:`RPT_LSB]) - 4'h1;
              next_play_addr = start_addr;
            end else begin
              next_state = ST_IDLE;
            end
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (stop_i) begin
      next_state = ST_IDLE;
      next_level = 7'h00;
      next_brake = 1'b0;
    end
    // Busy mirrors the state, so stop and end clear it at once
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      play_addr <= 8'h00;
      start_addr <= 8'h00;
      cur <= 24'h000000;
      rpt_left <= 4'h0;
      pat_left <= 4'h0;
      pat_armed <= 1'b0;
      level_o <= 7'h00;
      level_polarity_o <= 1'b0;
      brake_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      play_addr <= next_play_addr;
      start_addr <= next_start_addr;
      cur <= next_cur;
      rpt_left <= next_rpt_left;
      pat_left <= next_pat_left;
      pat_armed <= next_pat_armed;
      level_o <= next_level;
      level_polarity_o <= next_polarity;
      brake_o <= next_brake;
      busy_o <= next_busy;
    end
  end
endmodule

// ===== tb/haptic_player_sva.sv
// Port checks of the sample player
`timescale 1ns/1ps
module haptic_player_sva (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Async reset
  input wire logic [7:0] reg_addr_i, // Offset
  input wire logic reg_rd_i, // Read strobe
  input wire logic play_i, // Start
  input wire logic stop_i, // Abort
  input wire haptic_player_pkg::byte_t reg_rdata_o, // Read data
  input wire logic [6:0] level_o, // Amplitude
  input wire logic brake_o, // Braking
  input wire logic busy_o // Running
);
  import haptic_player_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_start;
    play_i && !busy_o;
  endsequence
  sequence s_bad_rd;
    reg_rd_i && (reg_addr_i < 8'h40 || reg_addr_i > 8'h43);
  endsequence
  start_busy_a: assert property (s_start |=> busy_o)
    else $error("busy did not follow play");
  busy_cause_a: assert property ($rose(busy_o) |-> $past(play_i))
    else $error("busy rose without play");
  stop_idle_a: assert property (stop_i |-> ##[1:2] !busy_o)
    else $error("stop did not end playback");
  brake_zero_a: assert property (brake_o |-> level_o == 7'h00)
    else $error("level driven while braking");
  brake_busy_a: assert property (brake_o |-> busy_o)
    else $error("brake outside playback");
  idle_zero_a: assert property (
    !busy_o && !$past(busy_o) |-> level_o == 7'h00)
    else $error("level driven while idle");
  unmapped_read_a: assert property (s_bad_rd |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
endmodule
bind haptic_pattern_sample_player haptic_player_sva sva (.clk_i(clk_i),
  .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .play_i(play_i), .stop_i(stop_i), .reg_rdata_o(reg_rdata_o),
  .level_o(level_o), .brake_o(brake_o), .busy_o(busy_o));

// ===== tb/haptic_pattern_sample_player_tb.sv
// Register and playback test of the sample player
`timescale 1ns/1ps
module haptic_pattern_sample_player_tb;
  import haptic_player_pkg::*;
  logic clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic play_i = 0, stop_i = 0, level_polarity_o, brake_o, busy_o;
  logic [7:0] reg_addr_i = 8'h00;
  byte_t reg_wdata_i = 8'h00, reg_rdata_o;
  logic [6:0] level_o, prv;
  logic direct, pol_bad;
  int n_fail = 0, n_compared = 0, rises, n55, nbrk, i;
  haptic_pattern_sample_player #(.STEP_CYCLES(4)) dut (.clk_i(clk_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .play_i(play_i),
    .stop_i(stop_i), .reg_rdata_o(reg_rdata_o), .level_o(level_o),
    .level_polarity_o(level_polarity_o), .brake_o(brake_o), .busy_o(busy_o));
  always #12.5 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp, input string what);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, exp, what);
  endtask
  task automatic ws(input logic [7:0] h, m, l);
    wr(8'h41, h);
    wr(8'h42, m);
    wr(8'h43, l);
  endtask
  task automatic go(input logic [7:0] p);
    wr(8'h40, p);
    @(negedge clk_i);
    play_i = 1'b1;
    @(negedge clk_i);
    play_i = 1'b0;
  endtask
  // Plays from pointer p and profiles the level trace
  task automatic run(input logic [7:0] p);
    go(p);
    rises = 0;
    n55 = 0;
    nbrk = 0;
    direct = 1'b0;
    pol_bad = 1'b0;
    prv = 7'h00;
    for (i = 0; i < 4000 && busy_o === 1'b1; i++) begin
      @(negedge clk_i);
      if (prv == 0 && level_o != 0) rises++;
      if (prv != 0 && level_o != 0 && level_o != prv) direct = 1'b1;
      n55 += (level_o == 7'h55);
      nbrk += brake_o;
      if (level_o == 7'h55 && level_polarity_o !== 1'b1) pol_bad = 1'b1;
      if (level_o == 7'h0A && level_polarity_o !== 1'b0) pol_bad = 1'b1;
      prv = level_o;
    end
    chk({7'h00, busy_o}, 8'h00, "busy end");
  endtask
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    rd(8'h40, 8'h00, "pointer reset");
    chk({1'b0, level_o}, 8'h00, "level reset");
    ws(8'h75, 8'h44, 8'h10);
    rd(8'h40, 8'h01, "pointer step");
    ws(8'h02, 8'h82, 8'h20);
    ws(8'h1F, 8'hC2, 8'h12);
    ws(8'hDF, 8'hC2, 8'h11);
    ws(8'h88, 8'h02, 8'h10);
    ws(8'h04, 8'h02, 8'h11);
    wr(8'h50, 8'hFF);
    rd(8'h44, 8'h00, "unmapped");
    wr(8'h40, 8'h00);
    rd(8'h41, 8'h75, "high readback");
    rd(8'h42, 8'h44, "middle readback");
    rd(8'h43, 8'h10, "low readback");
    run(8'h00);
    chk(rises[7:0], 8'h02, "samples played");
    chk({7'h00, n55 inside {[8:9]}}, 8'h01, "hold span");
    chk({7'h00, nbrk inside {[1:9]}}, 8'h01, "brake span");
    chk({7'h00, pol_bad}, 8'h00, "polarity");
    run(8'h02);
    chk(rises[7:0], 8'h03, "sample repeats");
    chk(nbrk[7:0], 8'h00, "no brake");
    run(8'h03);
    chk(rises[7:0], 8'h02, "pattern repeats");
    run(8'h04);
    chk(rises[7:0], 8'h03, "interp plays");
    chk({7'h00, direct}, 8'h01, "interp step");
    go(8'h00);
    repeat (3) @(negedge clk_i);
    stop_i = 1'b1;
    @(negedge clk_i);
    stop_i = 1'b0;
    @(negedge clk_i);
    chk({7'h00, busy_o}, 8'h00, "stop");
    chk({1'b0, level_o}, 8'h00, "stop level");
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
endmodule
